// ### design/monitor_channel_job_control.sv
// The implementer's own choices: the APB slave port and the address map.
`default_nettype none
// Contract
// - Seven channels: four fieldbus, two hardwired, one manual.
// - Up to seven jobs run at once, one per channel.
// - A job starts on any channel at any time, independently.
// - Results appear on the channel's own outputs by default.
// - The manual channel drives no result output.
// - Each channel takes run, recipe and learn, and reports status.
// - A job combines one to four instances evaluated together.
// - Learn cycles store reference data with each instance; the block keeps one refdat_q word loaded from inst_signal.
// - Learn set before start makes the cycle a learn cycle.
// - Run high starts and keeps the cycle; low stops it.
// - Motion permit is high exactly while the cycle runs.
// - Result outputs report evaluation outcome, several per job.
// - A fieldbus channel may route its result to a hardwired output.
// - Any sensor, analog or fieldbus input may feed an instance.
module monitor_channel_job_control #(
    parameter int NUM_CHAN = chan_pkg::NUM_CHAN,
    parameter int NUM_SRC  = 8,
    parameter int SIG_W    = 16
) (
    // Clock and reset
    input  wire logic                              core_clk,
    input  wire logic                              rst,
    // APB slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [11:0]                       paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // Controller requests, one per channel
    input  wire chan_pkg::chan_req_s [NUM_CHAN-1:0] chan_req,
    // Evaluation results from the strategy engine, one per channel
    input  wire logic [NUM_CHAN-1:0][chan_pkg::RES_W-1:0] inst_result,
    // Measurement sources for instance selection
    input  wire logic [NUM_SRC-1:0][SIG_W-1:0]     meas_src,
    // Status outputs
    output logic      [NUM_CHAN-1:0]               motion_permit,
    output logic      [NUM_CHAN-1:0]               learn_active,
    output logic [NUM_CHAN-1:0][chan_pkg::CODE_W-1:0] active_recipe,
    output logic [NUM_CHAN-1:0][chan_pkg::RES_W-1:0] result_out,
    output logic [NUM_CHAN-1:0][chan_pkg::MAX_INST-1:0] inst_enable,
    output logic      [SIG_W-1:0]                  inst_signal,
    output logic                                   ref_store,
    output logic                                   irq
);
    localparam int CW     = chan_pkg::CODE_W;
    localparam int RW     = chan_pkg::RES_W;
    localparam int SRC_WL = chan_pkg::SRC_W;
    localparam int MI     = chan_pkg::MAX_INST;

    chan_pkg::chan_state_e        state_q [NUM_CHAN];
    chan_pkg::chan_state_e        state_d [NUM_CHAN];
    logic [NUM_CHAN-1:0]          run_q;
    logic [NUM_CHAN-1:0][CW-1:0]  recipe_q;
    logic [NUM_CHAN-1:0][RW-1:0]  res_q;
    logic [31:0]                  route_q;
    logic [31:0]                  jobcfg_q;
    logic [SRC_WL-1:0]            srcsel_q;
    logic [31:0]                  refdat_q;
    logic [31:0]                  latch_q;
    logic [15:0]                  irq_st_q;
    logic [15:0]                  irq_en_q;
    logic [NUM_CHAN-1:0]          start_ev;
    logic [NUM_CHAN-1:0]          stop_ev;
    logic [NUM_CHAN-1:0]          learn_end;

    // Bus decode
    wire acc      = psel & penable;
    wire wr       = acc & pwrite;
    wire hit_rt   = paddr == chan_pkg::OFS_ROUTE;
    wire hit_run  = paddr == chan_pkg::OFS_RUN;
    wire hit_st   = paddr == chan_pkg::OFS_IRQ_ST;
    wire hit_clr  = paddr == chan_pkg::OFS_IRQ_CLR;
    wire hit_en   = paddr == chan_pkg::OFS_IRQ_EN;
    wire hit_job  = paddr == chan_pkg::OFS_JOBCFG;
    wire hit_src  = paddr == chan_pkg::OFS_SRCSEL;
    wire hit_ref  = paddr == chan_pkg::OFS_REFDAT;
    wire hit_lat  = paddr == chan_pkg::OFS_LATCH;
    wire hit_any  = hit_rt | hit_run | hit_st | hit_clr | hit_en |
                    hit_job | hit_src | hit_ref | hit_lat;
    wire [15:0] clr_mask = (wr && hit_clr) ? pwdata[15:0] : 16'h0000;

    // Zero-wait slave; unmapped addresses flag an error
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit_any;

    // Read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit_rt) begin
            prdata = route_q;
        end else if (hit_run) begin
            prdata = {16'h0000, 1'b0, learn_active, 1'b0, run_q};
        end else if (hit_st) begin
            prdata = {16'h0000, irq_st_q};
        end else if (hit_en) begin
            prdata = {16'h0000, irq_en_q};
        end else if (hit_job) begin
            prdata = jobcfg_q;
        end else if (hit_src) begin
            prdata = {29'h0000_0000, srcsel_q};
        end else if (hit_ref) begin
            prdata = refdat_q;
        end else if (hit_lat) begin
            prdata = latch_q;
        end
    end

    // Per-channel cycle control; each channel is fully independent
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        wire rq = chan_req[c].run_req;
        always_comb begin
            state_d[c] = state_q[c];
            case (state_q[c])
                chan_pkg::ST_IDLE: begin
                    if (rq) begin
                        state_d[c] = chan_req[c].learn_req ?
                            chan_pkg::ST_LEARN : chan_pkg::ST_RUN;
                    end
                end
                default: begin
                    if (!rq) begin
                        state_d[c] = chan_pkg::ST_IDLE;
                    end
                end
            endcase
        end
        assign start_ev[c]  = (state_q[c] == chan_pkg::ST_IDLE) & rq;
        assign stop_ev[c]   = (state_q[c] != chan_pkg::ST_IDLE) & ~rq;
        assign learn_end[c] = (state_q[c] == chan_pkg::ST_LEARN) & ~rq;

        // Latch recipe at start so mid-cycle changes cannot switch jobs
        always_ff @(posedge core_clk) begin
            if (rst) begin
                state_q[c]  <= chan_pkg::ST_IDLE;
                recipe_q[c] <= '0;
            end else begin
                state_q[c] <= state_d[c];
                if (start_ev[c]) begin
                    recipe_q[c] <= chan_req[c].recipe;
                end
            end
        end

        assign run_q[c]         = state_q[c] != chan_pkg::ST_IDLE;
        assign motion_permit[c] = run_q[c];
        assign learn_active[c]  = state_q[c] == chan_pkg::ST_LEARN;
        assign active_recipe[c] = recipe_q[c];
        // One to four instances; count field 0 means one
        assign inst_enable[c] =
            run_q[c] ? MI'((8'h02 <<
                jobcfg_q[2*c +: 2]) - 8'h01) : '0;

        // Result routing: own output, or a hardwired channel for bus ones
        wire rt_en = (c < chan_pkg::NUM_BUS_CHAN) &&
                     route_q[c + chan_pkg::ROUTE_EN_BIT];
        always_ff @(posedge core_clk) begin
            if (rst) begin
                res_q[c] <= '0;
            end else if (c == chan_pkg::MANUAL_CHAN) begin
                res_q[c] <= '0;
            end else if (c >= chan_pkg::NUM_BUS_CHAN &&
                         c < chan_pkg::MANUAL_CHAN) begin
                // Hardwired slot: takes routed bus results, else its own
                res_q[c] <= routed_any(c) ? routed_res(c) :
                            (run_q[c] ? inst_result[c] : '0);
            end else begin
                res_q[c] <= (run_q[c] && !rt_en) ?
                            inst_result[c] : '0;
            end
        end
        assign result_out[c] = res_q[c];
    end

    // Route bus channel b to hardwired slot 4 (bit 0) or 5 (bit 1)
    function automatic logic routed_any(input int slot);
        logic r;
        r = 1'b0;
        for (int b = 0; b < chan_pkg::NUM_BUS_CHAN; b++) begin
            if (route_q[chan_pkg::ROUTE_EN_BIT + b] && run_q[b] &&
                (int'(route_q[chan_pkg::ROUTE_DIO_BIT + b]) +
                 chan_pkg::NUM_BUS_CHAN == slot)) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction
    // Two bus channels on one slot are OR'ed; software should avoid that
    function automatic logic [RW-1:0] routed_res(input int slot);
        logic [RW-1:0] r;
        r = '0;
        for (int b = 0; b < chan_pkg::NUM_BUS_CHAN; b++) begin
            if (route_q[chan_pkg::ROUTE_EN_BIT + b] && run_q[b] &&
                (int'(route_q[chan_pkg::ROUTE_DIO_BIT + b]) +
                 chan_pkg::NUM_BUS_CHAN == slot)) begin
                r = r | inst_result[b];
            end
        end
        return r;
    endfunction

    // Instance source select: acoustic, analog or fieldbus inputs
    assign inst_signal = meas_src[srcsel_q];
    // Reference data captured when a learn cycle ends
    assign ref_store = |learn_end;

    // Software registers; hardware set wins over software clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            route_q  <= chan_pkg::ROUTE_RST;
            jobcfg_q <= chan_pkg::JOBCFG_RST;
            srcsel_q <= '0;
            refdat_q <= '0;
            latch_q  <= '0;
            irq_en_q <= '0;
            irq_st_q <= '0;
        end else begin
            if (wr && hit_rt)  route_q  <= pwdata;
            if (wr && hit_job) jobcfg_q <= pwdata;
            if (wr && hit_src) srcsel_q <= pwdata[SRC_WL-1:0];
            if (wr && hit_en)  irq_en_q <= pwdata[15:0];
            if (|learn_end) refdat_q <= {{(32-SIG_W){1'b0}}, inst_signal};
            if (|start_ev) latch_q <= {25'h000_0000, start_ev};
            irq_st_q <= (irq_st_q & ~clr_mask) |
                {1'b0, stop_ev, 1'b0, start_ev};
        end
    end
    assign irq = |(irq_st_q & irq_en_q);

    // Assertions
    property permit_tracks_p;
        @(posedge core_clk) disable iff (rst)
        chan_req[0].run_req |=> motion_permit[0];
    endproperty
    permit_follow_a: assert property (permit_tracks_p)
        else $error("permit not raised after run");
    stop_drop_a: assert property (@(posedge core_clk) disable iff (rst)
        !chan_req[1].run_req |=> !motion_permit[1])
        else $error("permit held after run dropped");
    learn_mode_a: assert property (@(posedge core_clk) disable iff (rst)
        (!motion_permit[2] && chan_req[2].run_req && chan_req[2].learn_req)
        |=> learn_active[2])
        else $error("learn cycle not entered");
    recipe_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        (motion_permit[3] && $past(motion_permit[3]))
        |-> $stable(active_recipe[3]))
        else $error("recipe changed mid cycle");
    manual_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
        result_out[chan_pkg::MANUAL_CHAN] == '0)
        else $error("manual channel drove result");
    idle_inst_a: assert property (@(posedge core_clk) disable iff (rst)
        !motion_permit[0] |-> inst_enable[0] == '0)
        else $error("instances enabled while idle");
    own_result_a: assert property (@(posedge core_clk) disable iff (rst)
        (motion_permit[1] && !route_q[1]) |=> result_out[1] ==
        $past(inst_result[1]))
        else $error("result not on own channel");
    indep_start_a: assert property (@(posedge core_clk) disable iff (rst)
        (chan_req[4].run_req && motion_permit[0]) |=> motion_permit[4])
        else $error("start blocked by other channel");
    ref_cap_a: assert property (@(posedge core_clk) disable iff (rst)
        ref_store |=> refdat_q[SIG_W-1:0] == $past(inst_signal))
        else $error("reference not stored");

    // Reference data moves only when a learn cycle ends
    ref_keep_a: assert property (@(posedge core_clk) disable iff (rst)
        !ref_store |=> $stable(refdat_q))
        else $error("reference changed outside learn end");
    // A source select write is in force from the next cycle on
    src_take_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr && hit_src) |=> srcsel_q == $past(pwdata[SRC_WL-1:0]))
        else $error("source select not taken");

    // Per-channel cycle checks; every channel obeys the same rules, so
    // a fault confined to one channel index still gets caught
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chk
        // Idle channel that sees its run request
        sequence start_s;
            !motion_permit[g] && chan_req[g].run_req;
        endsequence
        // Running channel whose run request has gone
        sequence stop_s;
            motion_permit[g] && !chan_req[g].run_req;
        endsequence
        // Running channel that keeps its run request
        sequence keep_s;
            motion_permit[g] && chan_req[g].run_req;
        endsequence

        // Learn level on the start edge picks the cycle kind
        cyc_start_a: assert property (@(posedge core_clk)
            disable iff (rst)
            start_s |=> motion_permit[g] &&
                (learn_active[g] == $past(chan_req[g].learn_req)))
            else $error("cycle start mode wrong");

        // Code present on the start edge becomes the active job
        code_take_a: assert property (@(posedge core_clk)
            disable iff (rst)
            start_s |=> active_recipe[g] == $past(chan_req[g].recipe))
            else $error("recipe not captured at start");

        // Dropping run ends the cycle together with its instances
        cyc_stop_a: assert property (@(posedge core_clk)
            disable iff (rst)
            stop_s |=> !motion_permit[g] && !learn_active[g] &&
                (inst_enable[g] == '0))
            else $error("cycle outlived its run request");

        // Cycle kind cannot change while run stays high
        mode_keep_a: assert property (@(posedge core_clk)
            disable iff (rst)
            keep_s |=> motion_permit[g] && $stable(learn_active[g]))
            else $error("cycle kind changed while running");

        // A running job enables a contiguous run of one to four instances
        inst_mask_a: assert property (@(posedge core_clk)
            disable iff (rst)
            motion_permit[g] |-> inst_enable[g][0] &&
                (((inst_enable[g] + 1'b1) & inst_enable[g]) == '0))
            else $error("instance mask not contiguous");

        // Cycle edges set their event bits even against a clear
        ev_start_a: assert property (@(posedge core_clk)
            disable iff (rst)
            start_s |=> irq_st_q[g])
            else $error("start event lost");
        ev_stop_a: assert property (@(posedge core_clk)
            disable iff (rst)
            stop_s |=> irq_st_q[chan_pkg::IRQ_STOP_BIT + g])
            else $error("stop event lost");

        // Bus channels only: a routed channel keeps its own output quiet
        if (g < chan_pkg::NUM_BUS_CHAN) begin : g_bus
            routed_off_a: assert property (@(posedge core_clk)
                disable iff (rst)
                route_q[chan_pkg::ROUTE_EN_BIT + g] |=> result_out[g] == '0)
                else $error("routed channel drove own output");
        end
    end
endmodule
`default_nettype wire

// ### design/chan_pkg.sv
`default_nettype none
package chan_pkg;
    // Channel counts (total, fieldbus), manual channel index, then widths
    localparam int NUM_CHAN     = 7;
    localparam int NUM_BUS_CHAN = 4;
    localparam int MANUAL_CHAN  = 6;
    localparam int CODE_W       = 4;
    localparam int RES_W        = 4;
    localparam int MAX_INST     = 4;
    localparam int SRC_W        = 3;

    // Register byte offsets
    localparam logic [11:0] OFS_ROUTE   = 12'h000;
    localparam logic [11:0] OFS_RUN     = 12'h004;
    localparam logic [11:0] OFS_IRQ_ST  = 12'h008;
    localparam logic [11:0] OFS_IRQ_CLR = 12'h00C;
    localparam logic [11:0] OFS_IRQ_EN  = 12'h010;
    localparam logic [11:0] OFS_JOBCFG  = 12'h014;
    localparam logic [11:0] OFS_SRCSEL  = 12'h018;
    localparam logic [11:0] OFS_REFDAT  = 12'h01C;
    localparam logic [11:0] OFS_LATCH   = 12'h020;

    // Reset values
    localparam logic [31:0] ROUTE_RST   = 32'h0000_0000;
    localparam logic [31:0] JOBCFG_RST  = 32'h0000_0000;

    // Field positions
    localparam int ROUTE_EN_BIT  = 0;
    localparam int ROUTE_DIO_BIT = 4;
    localparam int IRQ_STOP_BIT  = 8;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_RUN   = 2'b01,
        ST_LEARN = 2'b11
    } chan_state_e;

    // Per-channel request from the controller
    typedef struct packed {
        logic              run_req;
        logic              learn_req;
        logic [CODE_W-1:0] recipe;
    } chan_req_s;
endpackage
`default_nettype wire

// ### verification/ctrl_model.sv
`default_nettype none
// Machine controller on the far side of the channel inputs
module ctrl_model (
    // Clock
    input  wire logic                     core_clk,
    // Channel requests toward the block
    output var chan_pkg::chan_req_s [6:0] chan_req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial chan_req = '0;

    // Code and learn go out one edge ahead of run, so the capture is clean
    task automatic start(input logic [6:0] m, input logic [3:0] c,
                         input logic l);
        for (int i = 0; i < 7; i++) begin
            if (m[i]) begin
                chan_req[i].recipe    <= c;
                chan_req[i].learn_req <= l;
            end
        end
        @(posedge core_clk);
        for (int i = 0; i < 7; i++) begin
            if (m[i]) chan_req[i].run_req <= 1'b1;
        end
        @(posedge core_clk);
    endtask

    // Drop run; code lines then stop meaning anything, so they wander
    task automatic stop(input logic [6:0] m);
        for (int i = 0; i < 7; i++) begin
            if (m[i]) chan_req[i].run_req <= 1'b0;
        end
        @(posedge core_clk);
        for (int i = 0; i < 7; i++) begin
            if (m[i]) chan_req[i].recipe <= ~chan_req[i].recipe;
        end
        @(posedge core_clk);
    endtask

    // Misbehaviour on command: code changed in mid-cycle
    task automatic poke(input int ch, input logic [3:0] c);
        chan_req[ch].recipe <= c;
        @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// ### verification/monitor_channel_job_control_tb_top.sv
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module monitor_channel_job_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic ref_store, irq;
    logic [11:0]               paddr;
    logic [31:0]               pwdata, prdata, rd;
    chan_pkg::chan_req_s [6:0] chan_req;
    logic [6:0][3:0]           inst_result, active_recipe, result_out;
    logic [6:0][3:0]           inst_enable;
    logic [7:0][15:0]          meas_src;
    logic [6:0]                motion_permit, learn_active;
    logic [15:0]               inst_signal;
    int                        num_errors = 0;
    int                        n_checks = 0;
    int                        n_ref = 0;

    // Free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    monitor_channel_job_control dut (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan_req(chan_req),
        .inst_result(inst_result), .meas_src(meas_src),
        .motion_permit(motion_permit), .learn_active(learn_active),
        .active_recipe(active_recipe), .result_out(result_out),
        .inst_enable(inst_enable), .inst_signal(inst_signal),
        .ref_store(ref_store), .irq(irq));

    ctrl_model ctrl (.core_clk(core_clk), .chan_req(chan_req));

    // Counts learn-end strobes as the block presents them at an edge
    always @(posedge core_clk) begin
        if (ref_store === 1'b1) n_ref <= n_ref + 1;
    end

    // One APB transfer; entered and left just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic t_reset;
        @(negedge core_clk);
        `CHK(motion_permit, 7'h00)
        `CHK(irq, 1'b0)
        @(posedge core_clk);
        apb(1'b0, chan_pkg::OFS_ROUTE, 32'h0000_0000);
        `CHK(rd, chan_pkg::ROUTE_RST)
        apb(1'b0, 12'h040, 32'h0000_0000);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0000_0000)
        $display("test reset done");
    endtask

    // Recipe must stay latched although the lines move mid-cycle
    task automatic t_run;
        ctrl.start(7'h04, 4'h5, 1'b0);
        @(negedge core_clk);
        `CHK(motion_permit, 7'h04)
        `CHK(learn_active, 7'h00)
        @(posedge core_clk);
        ctrl.poke(2, 4'hC);
        @(negedge core_clk);
        `CHK(active_recipe[2], 4'h5)
        `CHK(motion_permit[2], 1'b1)
        @(posedge core_clk);
        ctrl.stop(7'h04);
        @(negedge core_clk);
        `CHK(motion_permit, 7'h00)
        @(posedge core_clk);
        $display("test run done");
    endtask

    // All channels at once, then one restarted while the rest run
    task automatic t_all;
        apb(1'b1, chan_pkg::OFS_JOBCFG, 32'h0000_0003);
        ctrl.start(7'h7F, 4'h9, 1'b0);
        @(negedge core_clk);
        `CHK(motion_permit, 7'h7F)
        `CHK(active_recipe[6], 4'h9)
        `CHK(inst_enable[0], 4'hF)
        `CHK(inst_enable[2], 4'h1)
        @(posedge core_clk);
        ctrl.stop(7'h02);
        ctrl.start(7'h02, 4'h3, 1'b0);
        @(negedge core_clk);
        `CHK(active_recipe[1], 4'h3)
        `CHK(active_recipe[0], 4'h9)
        @(posedge core_clk);
        apb(1'b0, chan_pkg::OFS_LATCH, 32'h0000_0000);
        `CHK(rd, 32'h0000_0002)
        ctrl.stop(7'h7F);
        @(negedge core_clk);
        `CHK(inst_enable[0], 4'h0)
        @(posedge core_clk);
        $display("test all done");
    endtask

    task automatic t_learn;
        apb(1'b1, chan_pkg::OFS_SRCSEL, 32'h0000_0002);
        @(negedge core_clk);
        `CHK(inst_signal, 16'hA5C3)
        @(posedge core_clk);
        ctrl.start(7'h10, 4'h7, 1'b1);
        @(negedge core_clk);
        `CHK(learn_active, 7'h10)
        @(posedge core_clk);
        apb(1'b0, chan_pkg::OFS_RUN, 32'h0000_0000);
        `CHK(rd, 32'h0000_1010)
        ctrl.stop(7'h10);
        apb(1'b0, chan_pkg::OFS_REFDAT, 32'h0000_0000);
        `CHK(rd, 32'h0000_A5C3)
        `CHK(n_ref, 1)
        $display("test learn done");
    endtask

    // Bus channel 1 routed onto hardwired slot 5
    task automatic t_route;
        inst_result <= {4'hF, 4'h1, 4'h6, 4'h0, 4'h0, 4'hA, 4'h0};
        ctrl.start(7'h7F, 4'h1, 1'b0);
        @(posedge core_clk);
        @(negedge core_clk);
        `CHK(result_out[1], 4'hA)
        `CHK(result_out[5], 4'h1)
        `CHK(result_out[6], 4'h0)
        @(posedge core_clk);
        apb(1'b1, chan_pkg::OFS_ROUTE, 32'h0000_0022);
        @(negedge core_clk);
        `CHK(result_out[5], 4'hA)
        `CHK(result_out[1], 4'h0)
        `CHK(result_out[4], 4'h6)
        @(posedge core_clk);
        ctrl.stop(7'h7F);
        $display("test route done");
    endtask

    // Start event enabled, stop event masked
    task automatic t_irq;
        apb(1'b1, chan_pkg::OFS_IRQ_CLR, 32'h0000_7F7F);
        apb(1'b1, chan_pkg::OFS_IRQ_EN, 32'h0000_0001);
        ctrl.start(7'h01, 4'h2, 1'b0);
        @(negedge core_clk);
        `CHK(irq, 1'b1)
        @(posedge core_clk);
        apb(1'b1, chan_pkg::OFS_IRQ_CLR, 32'h0000_0001);
        ctrl.stop(7'h01);
        apb(1'b0, chan_pkg::OFS_IRQ_ST, 32'h0000_0000);
        `CHK(rd, 32'h0000_0100)
        @(negedge core_clk);
        `CHK(irq, 1'b0)
        $display("test irq done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite} = 3'b000;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        inst_result = '0;
        for (int i = 0; i < 8; i++) meas_src[i] = 16'(16'h1111 * i);
        meas_src[2] = 16'hA5C3;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset;
        t_run;
        t_all;
        t_learn;
        t_route;
        t_irq;
        summarize;
    end

    // Hang guard, well past the fewer than a hundred cycles the tests need
    initial begin
        #(40 * 5000);
        num_errors++;
        summarize;
    end
endmodule
`default_nettype wire
